// ### rtl/iedc_regs.vh
// Register map, field positions and timing constants of the incremental encoder decoder.
`ifndef IEDC_REGS_VH
`define IEDC_REGS_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define IEDC_ADR_W 8
`define IEDC_OFF_CTRL 8'h00
`define IEDC_OFF_POS 8'h04
`define IEDC_OFF_REFPOS 8'h08
`define IEDC_OFF_STATUS 8'h0c
`define IEDC_OFF_CLR 8'h10
`define IEDC_OFF_EN 8'h14
`define IEDC_OFF_LIVE 8'h18

// ************************************************************
// Control fields
// ************************************************************
`define IEDC_CTRL_MULT_LO 0
`define IEDC_CTRL_MULT_HI 1
`define IEDC_CTRL_INV 2
`define IEDC_CTRL_ZERO 3
`define IEDC_CTRL_RST 8'h00
`define IEDC_MULT_X1 2'h0
`define IEDC_MULT_X2 2'h1
`define IEDC_MULT_X4 2'h2

// ************************************************************
// Status, clear and enable fields
// ************************************************************
`define IEDC_EV_W 5
`define IEDC_EV_COPH 0
`define IEDC_EV_FAULT 1
`define IEDC_EV_TRI 2
`define IEDC_EV_REF 3
`define IEDC_EV_REFCLR 4
`define IEDC_EN_RST 5'h00

// ************************************************************
// Timing
// ************************************************************
`define IEDC_CLK_MHZ 200
`define IEDC_COPH_NS 1200
`define IEDC_REFCLR_NS 100
`define IEDC_TRI_NS 100
`define IEDC_EDGE_NS 150
`define IEDC_COPH_CYC ((`IEDC_COPH_NS * `IEDC_CLK_MHZ + 999) / 1000)
`define IEDC_REFCLR_CYC ((`IEDC_REFCLR_NS * `IEDC_CLK_MHZ + 999) / 1000)
`define IEDC_TRI_CYC ((`IEDC_TRI_NS * `IEDC_CLK_MHZ + 999) / 1000)
`define IEDC_EDGE_CYC ((`IEDC_EDGE_NS * `IEDC_CLK_MHZ + 999) / 1000)

`endif

// ### rtl/iedc_sync.v
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none

module iedc_sync #(
  parameter WIDTH = 7,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // ************************************************************
  // One synchroniser per bit
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_i) begin
        if (rst_i) begin
          meta_r[i] <= RST_VAL[i];
          sync_r[i] <= RST_VAL[i];
        end else begin
          meta_r[i] <= d_i[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign q_o = sync_r;

endmodule // iedc_sync

`default_nettype wire

// ### rtl/iedc_quad.v
// Quadrature edge decoder with x1, x2 and x4 count multiplication.
`timescale 1ns/1ps
`default_nettype none
`include "iedc_regs.vh"

module iedc_quad (
  input wire clk_i,
  input wire rst_i,
  input wire track_a_i,
  input wire track_b_i,
  input wire [1:0] mult_i,
  input wire inv_i,
  output reg up_o,
  output reg dn_o,
  output reg edge_o
);

  reg a_r;
  reg b_r;
  reg up_raw;
  reg dn_raw;
  wire a_chg;
  wire b_chg;

  assign a_chg = track_a_i ^ a_r;
  assign b_chg = track_b_i ^ b_r;

  // ************************************************************
  // Direction and multiplication
  // ************************************************************
  always @* begin
    up_raw = 1'b0;
    dn_raw = 1'b0;
    if (a_chg && !b_chg) begin
      if (mult_i == `IEDC_MULT_X1) begin
        up_raw = !track_b_i && track_a_i;
        dn_raw = !track_b_i && !track_a_i;
      end else begin
        up_raw = track_a_i != track_b_i;
        dn_raw = track_a_i == track_b_i;
      end
    end else if (b_chg && !a_chg && mult_i == `IEDC_MULT_X4) begin
      up_raw = track_b_i == track_a_i;
      dn_raw = track_b_i != track_a_i;
    end
  end

  // Each sampled edge is judged only against the previous sample, so a reversal on one track
  // with no spacing counts back at once, and a reversal shorter than a clock cancels out.
  always @(posedge clk_i) begin
    if (rst_i) begin
      // Under reset the track history follows the pins, so the first sample afterwards is no edge.
      a_r <= track_a_i;
      b_r <= track_b_i;
      up_o <= 1'b0;
      dn_o <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      a_r <= track_a_i;
      b_r <= track_b_i;
      up_o <= inv_i ? dn_raw : up_raw;
      dn_o <= inv_i ? up_raw : dn_raw;
      edge_o <= a_chg | b_chg;
    end
  end

endmodule // iedc_quad

`default_nettype wire

// ### rtl/iedc_top.v
// Incremental encoder decoder with Wishbone registers, track monitoring and interrupt.
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "iedc_regs.vh"

module iedc_top #(
  parameter POS_W = 32,
  parameter COPH_CYC = `IEDC_COPH_CYC,
  parameter REFCLR_CYC = `IEDC_REFCLR_CYC,
  parameter TRI_CYC = `IEDC_TRI_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`IEDC_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire track_a_p_i,
  input wire track_a_n_i,
  input wire track_b_p_i,
  input wire track_b_n_i,
  input wire reference_mark_p_i,
  input wire reference_mark_n_i,
  input wire fault_n_i,
  output wire irq_o,
  output wire meas_err_o
);

  // ************************************************************
  // Input synchronisation
  // ************************************************************
  wire [6:0] pins_s;
  wire a_p;
  wire a_n;
  wire b_p;
  wire b_n;
  wire r_p;
  wire r_n;
  wire fault_n_s;

  iedc_sync #(
    .WIDTH(7),
    .RST_VAL(7'h40)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({fault_n_i, reference_mark_n_i, reference_mark_p_i, track_b_n_i, track_b_p_i,
          track_a_n_i, track_a_p_i}),
    .q_o(pins_s)
  );

  assign a_p = pins_s[0];
  assign a_n = pins_s[1];
  assign b_p = pins_s[2];
  assign b_n = pins_s[3];
  assign r_p = pins_s[4];
  assign r_n = pins_s[5];
  assign fault_n_s = pins_s[6];

  // ************************************************************
  // Start-up settling
  // ************************************************************
  reg [1:0] warm_r;
  wire settled;
  wire quad_rst;

  // Holds decoding and the cophasal and high-impedance monitoring off until the synchroniser shows real pin levels.
  assign settled = warm_r == 2'h3;
  assign quad_rst = rst_i || !settled;

  always @(posedge clk_i) begin
    if (rst_i) begin
      warm_r <= 2'h0;
    end else if (!settled) begin
      warm_r <= warm_r + 2'h1;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  reg [1:0] mult_r;
  reg inv_r;
  reg zero_r;
  reg [`IEDC_EV_W-1:0] en_r;
  reg [`IEDC_EV_W-1:0] stat_r;
  reg [`IEDC_EV_W-1:0] stat_nxt;
  reg [`IEDC_EV_W-1:0] clr_w;
  wire wr_stb;
  wire rd_stb;

  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  always @(posedge clk_i) begin
    if (rst_i) begin
      mult_r <= `IEDC_MULT_X1;
      inv_r <= 1'b0;
      zero_r <= 1'b0;
      en_r <= `IEDC_EN_RST;
    end else begin
      zero_r <= 1'b0;
      if (wr_stb && wb_adr_i == `IEDC_OFF_CTRL) begin
        mult_r <= wb_dat_i[`IEDC_CTRL_MULT_HI:`IEDC_CTRL_MULT_LO];
        inv_r <= wb_dat_i[`IEDC_CTRL_INV];
        zero_r <= wb_dat_i[`IEDC_CTRL_ZERO];
      end
      if (wr_stb && wb_adr_i == `IEDC_OFF_EN) begin
        en_r <= wb_dat_i[`IEDC_EV_W-1:0];
      end
    end
  end

  always @* begin
    clr_w = {`IEDC_EV_W{1'b0}};
    if (wr_stb && wb_adr_i == `IEDC_OFF_CLR) begin
      clr_w = wb_dat_i[`IEDC_EV_W-1:0];
    end
  end

  // ************************************************************
  // Edge decoding and position counter
  // ************************************************************
  wire cnt_up;
  wire cnt_dn;
  wire trk_edge;
  wire a_lvl;
  wire b_lvl;
  wire r_lvl;
  reg signed [POS_W-1:0] pos_r;
  reg signed [POS_W-1:0] refpos_r;

  assign a_lvl = a_p;
  assign b_lvl = b_p;
  assign r_lvl = r_p;

  iedc_quad u_quad (
    .clk_i(clk_i),
    .rst_i(quad_rst),
    .track_a_i(a_lvl),
    .track_b_i(b_lvl),
    .mult_i(mult_r),
    .inv_i(inv_r),
    .up_o(cnt_up),
    .dn_o(cnt_dn),
    .edge_o(trk_edge)
  );

  // At 5 ns per sample a 1 MHz track with 150 ns edge spacing gives 30 samples per edge.
  always @(posedge clk_i) begin
    if (rst_i || zero_r) begin
      pos_r <= {POS_W{1'b0}};
    end else if (cnt_up) begin
      pos_r <= pos_r + {{(POS_W-1){1'b0}}, 1'b1};
    end else if (cnt_dn) begin
      pos_r <= pos_r - {{(POS_W-1){1'b0}}, 1'b1};
    end
  end

  // ************************************************************
  // Reference mark qualification
  // ************************************************************
  reg [7:0] since_edge_r;
  reg r_prev_r;
  wire ref_rise;
  wire ref_clear;
  wire ref_qual;

  assign ref_rise = settled && r_lvl && !r_prev_r;
  assign ref_clear = since_edge_r >= REFCLR_CYC[7:0];
  assign ref_qual = ref_rise && a_lvl && b_lvl && ref_clear;

  always @(posedge clk_i) begin
    if (rst_i) begin
      since_edge_r <= 8'h00;
      r_prev_r <= 1'b0;
      refpos_r <= {POS_W{1'b0}};
    end else begin
      r_prev_r <= r_lvl;
      if (trk_edge) begin
        since_edge_r <= 8'h00;
      end else if (since_edge_r != 8'hff) begin
        since_edge_r <= since_edge_r + 8'h01;
      end
      if (ref_qual) begin
        refpos_r <= pos_r;
      end
    end
  end

  // ************************************************************
  // Measuring system monitoring
  // ************************************************************
  reg [10:0] coph_cnt_r;
  reg [10:0] tri_cnt_r;
  wire cophasal;
  wire tristate;
  wire coph_err;
  wire tri_err;
  wire fault_err;

  assign cophasal = (a_lvl == b_lvl) && (b_lvl == r_lvl);
  assign tristate = (a_p == a_n) || (b_p == b_n) || (r_p == r_n);
  assign coph_err = coph_cnt_r >= COPH_CYC[10:0];
  assign tri_err = tri_cnt_r >= TRI_CYC[10:0];
  assign fault_err = !fault_n_s;

  always @(posedge clk_i) begin
    if (rst_i || !settled) begin
      coph_cnt_r <= 11'h000;
      tri_cnt_r <= 11'h000;
    end else begin
      if (!cophasal) begin
        coph_cnt_r <= 11'h000;
      end else if (!coph_err) begin
        coph_cnt_r <= coph_cnt_r + 11'h001;
      end
      if (!tristate) begin
        tri_cnt_r <= 11'h000;
      end else if (!tri_err) begin
        tri_cnt_r <= tri_cnt_r + 11'h001;
      end
    end
  end

  // ************************************************************
  // Sticky status and interrupt
  // ************************************************************
  wire [`IEDC_EV_W-1:0] ev_set;

  assign ev_set = {ref_rise && !ref_clear && a_lvl && b_lvl, ref_qual, tri_err, fault_err, coph_err};

  always @* begin
    stat_nxt = (stat_r & ~clr_w) | ev_set;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= {`IEDC_EV_W{1'b0}};
    end else begin
      stat_r <= stat_nxt;
    end
  end

  assign irq_o = |(stat_r & en_r);
  assign meas_err_o = stat_r[`IEDC_EV_COPH] | stat_r[`IEDC_EV_FAULT] | stat_r[`IEDC_EV_TRI];

  // ************************************************************
  // Wishbone read path and acknowledge
  // ************************************************************
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `IEDC_OFF_CTRL: begin
        rd_mux[`IEDC_CTRL_MULT_HI:`IEDC_CTRL_MULT_LO] = mult_r;
        rd_mux[`IEDC_CTRL_INV] = inv_r;
      end
      `IEDC_OFF_POS: begin
        rd_mux[POS_W-1:0] = pos_r;
      end
      `IEDC_OFF_REFPOS: begin
        rd_mux[POS_W-1:0] = refpos_r;
      end
      `IEDC_OFF_STATUS: begin
        rd_mux[`IEDC_EV_W-1:0] = stat_r;
      end
      `IEDC_OFF_EN: begin
        rd_mux[`IEDC_EV_W-1:0] = en_r;
      end
      `IEDC_OFF_LIVE: begin
        rd_mux[4:0] = {tristate, fault_n_s, r_lvl, b_lvl, a_lvl};
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (rd_stb) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

endmodule // iedc_top

`default_nettype wire

// ### tb/iedc_chk_assertions.sv
// Concurrent checks on the ports of the encoder decoder.
`timescale 1ns/1ps
`default_nettype none
module iedc_chk #(
  parameter COPH_CYC = 240,
  parameter TRI_CYC = 20
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire track_a_p_i,
  input wire track_a_n_i,
  input wire track_b_p_i,
  input wire track_b_n_i,
  input wire reference_mark_p_i,
  input wire reference_mark_n_i,
  input wire fault_n_i,
  input wire irq_o,
  input wire meas_err_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire hz_w = (track_a_p_i == track_a_n_i) || (track_b_p_i == track_b_n_i)
    || (reference_mark_p_i == reference_mark_n_i);
  wire coph_w = !hz_w && track_a_p_i == track_b_p_i && track_b_p_i == reference_mark_p_i;
  int tri_cnt;
  int coph_cnt;
  // Counts how long the high-impedance and the cophasal condition have held without a break.
  always @(posedge clk_i) begin
    tri_cnt <= (rst_i || !hz_w) ? 0 : tri_cnt + 1;
    coph_cnt <= (rst_i || !coph_w) ? 0 : coph_cnt + 1;
  end
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h1c |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && !meas_err_o)
    else $error("outputs active after reset");
  chk_fault_error: assert property (!fault_n_i [*3] |-> ##[0:3] meas_err_o)
    else $error("fault input not reported");
  chk_error_sticky: assert property (meas_err_o
    && !(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h10) |=> meas_err_o) else $error("error flag dropped");
  chk_tri_error: assert property (tri_cnt >= TRI_CYC + 5 |-> meas_err_o)
    else $error("high impedance not reported");
  chk_coph_error: assert property (coph_cnt >= COPH_CYC + 5 |-> meas_err_o)
    else $error("cophasal state not reported");
  cover property (wb_ack_o && wb_we_i);
  cover property ($rose(meas_err_o));
  cover property ($rose(irq_o));
endmodule // iedc_chk
bind iedc_top iedc_chk #(.COPH_CYC(COPH_CYC), .TRI_CYC(TRI_CYC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .track_a_p_i(track_a_p_i), .track_a_n_i(track_a_n_i), .track_b_p_i(track_b_p_i),
  .track_b_n_i(track_b_n_i), .reference_mark_p_i(reference_mark_p_i),
  .reference_mark_n_i(reference_mark_n_i), .fault_n_i(fault_n_i), .irq_o(irq_o), .meas_err_o(meas_err_o));
`default_nettype wire

// ### tb/iedc_enc.sv
// Encoder model driving quadrature tracks, reference mark and fault line.
`timescale 1ns/1ps
`default_nettype none
module iedc_enc (
  input wire logic clk_i,
  output logic a_p_o,
  output logic a_n_o,
  output logic b_p_o,
  output logic b_n_o,
  output logic r_p_o,
  output logic r_n_o,
  output logic flt_n_o
);
  logic [1:0] ph = 2'h1;
  logic hz = 1'b0;
  logic tg = 1'b0;
  logic r = 1'b0;
  logic flt_n = 1'b1;
  // Released drivers leave both lines of track A equal and changing every cycle.
  always @(posedge clk_i) tg <= ~tg;
  assign a_p_o = hz ? tg : ph[0] ^ ph[1];
  assign a_n_o = hz ? tg : ~(ph[0] ^ ph[1]);
  assign b_p_o = ph[1];
  assign b_n_o = ~ph[1];
  assign r_p_o = r;
  assign r_n_o = ~r;
  assign flt_n_o = flt_n;
  // Moves one quadrature step, forward when up is set, then rests.
  task automatic mv(input logic up, input int gap);
    @(posedge clk_i);
    ph <= up ? ph + 2'h1 : ph - 2'h1;
    repeat (gap) @(posedge clk_i);
  endtask
endmodule // iedc_enc
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking testbench of the encoder decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq_o, meas_err_o, a_p, a_n, b_p, b_n, r_p, r_n, flt_n;
  int bad_count = 0;
  int checks_done = 0;
  int seed = 32'h4157;
  int pos, r;
  logic dir, last;
  logic [31:0] mexp [5] = '{32'h2, 32'h4, 32'h8, 32'hfffffff8, 32'h4};
  logic [31:0] mctl [5] = '{32'h8, 32'h9, 32'ha, 32'he, 32'hb};
  logic [31:0] exp_q [$];
  always #2.5 clk_i = ~clk_i;
  iedc_top #(.COPH_CYC(8), .REFCLR_CYC(4), .TRI_CYC(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .track_a_p_i(a_p), .track_a_n_i(a_n),
    .track_b_p_i(b_p), .track_b_n_i(b_n), .reference_mark_p_i(r_p), .reference_mark_n_i(r_n),
    .fault_n_i(flt_n), .irq_o(irq_o), .meas_err_o(meas_err_o));
  iedc_enc u_enc (.clk_i(clk_i), .a_p_o(a_p), .a_n_o(a_n), .b_p_o(b_p), .b_n_o(b_n), .r_p_o(r_p),
    .r_n_o(r_n), .flt_n_o(flt_n));
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      end_of_test();
    end else begin
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    wb(1'b1, adr, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, adr, 32'h0, 4'hf);
  endtask
  // Compares each read answer with the oldest expected value.
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk(wb_dat_o, exp_q.pop_front());
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h1c, 32'h0);
    rd(8'h18, 32'h9);
    chk_bit(meas_err_o, 1'b0);
    wb(1'b1, 8'h00, 32'h2, 4'he);
    rd(8'h00, 32'h0);
    for (int m = 0; m < 5; m++) begin
      wr(8'h00, mctl[m]);
      repeat (8) u_enc.mv(1'b1, 30);
      rd(8'h04, mexp[m]);
    end
    wr(8'h00, 32'ha);
    pos = 0;
    last = 1'b1;
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      dir = r[0];
      if (dir == last) repeat (29) @(posedge clk_i);
      u_enc.mv(dir, 1);
      pos += dir ? 1 : -1;
      last = dir;
    end
    repeat (6) @(posedge clk_i);
    rd(8'h04, pos);
    u_enc.ph <= 2'h1;
    repeat (10) @(posedge clk_i);
    wr(8'h10, 32'h1f);
    wr(8'h14, 32'h2);
    u_enc.flt_n <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk_bit(meas_err_o, 1'b1);
    chk_bit(irq_o, 1'b1);
    u_enc.flt_n <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk_bit(meas_err_o, 1'b1);
    rd(8'h0c, 32'h2);
    wr(8'h14, 32'h0);
    chk_bit(irq_o, 1'b0);
    wr(8'h10, 32'h2);
    chk_bit(meas_err_o, 1'b0);
    u_enc.hz <= 1'b1;
    repeat (12) @(posedge clk_i);
    u_enc.hz <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(8'h0c, 32'h4);
    wr(8'h10, 32'h1f);
    u_enc.ph <= 2'h0;
    repeat (20) @(posedge clk_i);
    rd(8'h0c, 32'h1);
    u_enc.ph <= 2'h1;
    repeat (4) @(posedge clk_i);
    wr(8'h10, 32'h1f);
    wr(8'h00, 32'ha);
    u_enc.mv(1'b1, 30);
    u_enc.r <= 1'b1;
    repeat (4) @(posedge clk_i);
    u_enc.r <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(8'h08, 32'h1);
    rd(8'h0c, 32'h8);
    wr(8'h10, 32'h1f);
    u_enc.mv(1'b1, 1);
    u_enc.mv(1'b0, 0);
    u_enc.r <= 1'b1;
    repeat (4) @(posedge clk_i);
    u_enc.r <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(8'h0c, 32'h10);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
